//--- idpc_pkg.sv
// constants and types shared by the inverter drive power controller
`default_nettype none
package idpc_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;
    localparam int ITER_TIME_US = 1000;
    localparam int ITER_CYCLES = ITER_TIME_US * CLK_MHZ;
    localparam int LOOP_ITERS = 8;
    // ------------------------------------------------------------
    // operating point units: hz, 0.036 deg, 0.002 percent
    // ------------------------------------------------------------
    localparam logic [17:0] F_MIN_HZ = 18'd110_000;
    localparam logic [17:0] F_HB_XO_HZ = 18'd125_000;
    localparam logic [17:0] F_FB_XO_HZ = 18'd160_000;
    localparam logic [17:0] F_MAX_HZ = 18'd205_000;
    localparam logic [17:0] F_PING_HZ = 18'd175_000;
    localparam logic [17:0] F_BAND1_HZ = 18'd130_000;
    localparam logic [17:0] F_BAND2_HZ = 18'd140_000;
    localparam logic [17:0] F_BAND4_HZ = 18'd180_000;
    localparam logic [11:0] PH_MAX = 12'd2500;
    localparam logic [14:0] DUTY_MIN = 15'd5000;
    localparam logic [14:0] DUTY_MAX = 15'd25000;
    // phase units in a full turn, and scale factors for the pwm core
    localparam logic [18:0] PH_WORD_SCALE = 19'h6_8DB9;
    localparam logic [23:0] F_INC_SCALE = 24'hD6_BF95;
    localparam logic [16:0] DUTY_THR_SCALE = 17'h1_4F8B;
    // ------------------------------------------------------------
    // pid gains (x100) and limits
    // ------------------------------------------------------------
    localparam logic [15:0] KP_FREQ_X100 = 16'h03E8;
    localparam logic [15:0] KI_FREQ_X100 = 16'h0005;
    localparam logic [15:0] KP_AUX_X100 = 16'h0064;
    localparam logic [15:0] KI_AUX_X100 = 16'h0001;
    localparam int PID_I_LIMIT = 3000;
    localparam int PID_OUT_LIMIT = 20000;
    localparam int GAIN_DIV = 100;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SEG_HB_DUTY,
        SEG_HB_FREQ,
        SEG_FB_PHASE,
        SEG_FB_FREQ_LO,
        SEG_FB_FREQ_HI
    } idpc_seg_t;

    typedef struct packed {
        logic full_bridge_mode;
        logic [17:0] switching_frequency;
        logic [11:0] phase_offset;
        logic [14:0] duty_cycle;
    } idpc_op_t;
endpackage : idpc_pkg
`default_nettype wire

//--- idpc_pid.sv
// pid step for the power control loop, derivative gain zero
`default_nettype none
module idpc_pid
    import idpc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clear,
    input wire logic start,
    input wire logic signed [15:0] err,
    input wire logic [15:0] kp_x100,
    input wire logic [15:0] ki_x100,
    output logic out_valid_ff,
    output logic signed [15:0] out_ff
);
    logic signed [31:0] integ_ff;
    logic signed [31:0] nxt_integ;
    logic signed [31:0] nxt_out;
    logic signed [31:0] e32;
    logic signed [31:0] sum;

    function automatic logic signed [31:0] clamp(input logic signed [31:0] v, input logic signed [31:0] lim);
        if (v > lim) begin
            return lim;
        end
        if (v < -lim) begin
            return -lim;
        end
        return v;
    endfunction : clamp

    // integral kept at x100 scale so the fractional gains do not truncate
    always_comb begin
        e32 = 32'(err);
        nxt_integ = clamp(integ_ff + e32 * $signed({16'h0000, ki_x100}),
                          32'(PID_I_LIMIT * GAIN_DIV));
        sum = (e32 * $signed({16'h0000, kp_x100}) + nxt_integ) / 32'(GAIN_DIV);
        nxt_out = clamp(sum, 32'(PID_OUT_LIMIT));
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            integ_ff <= 32'sh0000_0000;
        end else if (clear) begin
            integ_ff <= 32'sh0000_0000;
        end else if (start) begin
            integ_ff <= nxt_integ;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            out_valid_ff <= 1'b0;
            out_ff <= 16'sh0000;
        end else begin
            out_valid_ff <= start;
            if (start) begin
                out_ff <= nxt_out[15:0];
            end
        end
    end
endmodule : idpc_pid
`default_nettype wire

//--- idpc_ctrl.sv
// inverter drive power controller: trajectory, pid loop and bridge pwm
//
// Operation
// - keep frequency, phase, duty inside ranges
// - higher f, phase or lower duty reduce power
// - frequency step fine enough per band
// - phase step 0.18 degrees or finer
// - duty step 0.1 percent or finer
// - ping: half bridge, 50% duty, 170-180kHz
// - pid loop on frequency, duty or phase
// - coil current measured to 7 mA
// - basic profile stays half bridge only
// - basic profile at 205kHz: duty control
// - basic profile below 205kHz: frequency control
// - extended profile picks bridge by parameters
// - crossover changes both variables at once
// - rising half bridge: duty, then frequency
// - rising crossover: 125kHz hb to 160kHz fb
// - rising full bridge: phase, then frequency
// - falling full bridge: f, phase, f
// - falling crossover: 205kHz fb to 125kHz hb
// - falling half bridge: frequency, then duty
// - crossover aborts loop until next message
// - fb uses f and phase, hb f and duty
// - frequency pid gains and limits
// - frequency scaling by band
// - phase pid gains and scaling
// - duty pid gains and scaling
`default_nettype none
module idpc_ctrl
    import idpc_pkg::*;
#(
    parameter int ITER_CYC = ITER_CYCLES,
    parameter int LOOP_N = LOOP_ITERS
)
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic power_enable,
    input wire logic ping_start,
    input wire logic extended_profile,
    input wire logic ctrl_err_valid,
    input wire logic [15:0] target_current_ma,
    input wire logic [15:0] coil_current_ma,
    output logic leg_a_drive_ff,
    output logic leg_b_drive_ff,
    output logic half_bridge_mode_ff,
    output idpc_op_t op_point_ff,
    output logic loop_active_ff,
    output logic crossover_ff
);
    // ------------------------------------------------------------
    // loop sequencing
    // ------------------------------------------------------------
    idpc_seg_t seg_ff;
    idpc_seg_t nxt_seg;
    idpc_op_t nxt_op;
    logic [31:0] iter_cnt_ff;
    logic [7:0] iters_left_ff;
    logic pid_start_ff;
    logic pid_valid;
    logic signed [15:0] pid_out;
    logic signed [15:0] pid_err_ff;
    logic signed [16:0] err_wide;
    logic [15:0] kp_sel;
    logic [15:0] ki_sel;
    logic xo;
    logic iter_tick;

    assign iter_tick = loop_active_ff && (iter_cnt_ff == 32'(ITER_CYC - 1));
    assign err_wide = $signed({1'b0, target_current_ma}) - $signed({1'b0, coil_current_ma});

    // one pid iteration per tick, each message runs a fresh loop
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            loop_active_ff <= 1'b0;
            iter_cnt_ff <= 32'h0000_0000;
            iters_left_ff <= 8'h00;
        end else if (!power_enable || ping_start) begin
            loop_active_ff <= 1'b0;
            iter_cnt_ff <= 32'h0000_0000;
            iters_left_ff <= 8'h00;
        end else if (ctrl_err_valid) begin
            loop_active_ff <= 1'b1;
            iter_cnt_ff <= 32'h0000_0000;
            iters_left_ff <= 8'(LOOP_N);
        end else if (pid_valid && (xo || iters_left_ff == 8'h00)) begin
            loop_active_ff <= 1'b0;
            iters_left_ff <= 8'h00;
        end else if (iter_tick) begin
            iter_cnt_ff <= 32'h0000_0000;
            iters_left_ff <= iters_left_ff - 8'h01;
        end else if (loop_active_ff) begin
            iter_cnt_ff <= iter_cnt_ff + 32'h0000_0001;
        end
    end

    // current in 1 mA steps, finer than the 7 mA needed
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pid_start_ff <= 1'b0;
            pid_err_ff <= 16'sh0000;
        end else begin
            pid_start_ff <= iter_tick;
            if (iter_tick) begin
                pid_err_ff <= (err_wide[16] ^ err_wide[15]) ? {err_wide[16], {15{!err_wide[16]}}} :
                              err_wide[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // gain selection
    // ------------------------------------------------------------
    always_comb begin
        if (seg_ff == SEG_HB_FREQ || seg_ff == SEG_FB_FREQ_LO || seg_ff == SEG_FB_FREQ_HI) begin
            kp_sel = KP_FREQ_X100;
            ki_sel = KI_FREQ_X100;
        end else begin
            kp_sel = KP_AUX_X100;
            ki_sel = KI_AUX_X100;
        end
    end

    idpc_pid u_pid (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .clear(ctrl_err_valid),
        .start(pid_start_ff),
        .err(pid_err_ff),
        .kp_x100(kp_sel),
        .ki_x100(ki_sel),
        .out_valid_ff(pid_valid),
        .out_ff(pid_out)
    );

    // ------------------------------------------------------------
    // trajectory step
    // ------------------------------------------------------------
    // scale in half hertz per pid unit for the present band
    function automatic logic signed [31:0] band_half_hz(input logic [17:0] f);
        if (f < F_BAND1_HZ) begin
            return 32'sd2;
        end
        if (f < F_BAND2_HZ) begin
            return 32'sd3;
        end
        if (f < F_FB_XO_HZ) begin
            return 32'sd4;
        end
        if (f < F_BAND4_HZ) begin
            return 32'sd6;
        end
        return 32'sd10;
    endfunction : band_half_hz

    logic signed [31:0] d32;
    logic signed [31:0] f_new;
    logic signed [31:0] aux_new;

    // positive pid output asks for more power: lower f, lower phase, higher duty
    always_comb begin
        nxt_op = op_point_ff;
        nxt_seg = seg_ff;
        xo = 1'b0;
        d32 = 32'(pid_out);
        f_new = $signed({14'h0000, op_point_ff.switching_frequency}) -
                ((d32 * band_half_hz(op_point_ff.switching_frequency)) >>> 1);
        aux_new = 32'sh0000_0000;
        case (seg_ff)
            SEG_HB_DUTY: begin
                aux_new = $signed({17'h0000, op_point_ff.duty_cycle}) + d32;
                nxt_op.switching_frequency = F_MAX_HZ;
                if (aux_new >= $signed({17'h0000, DUTY_MAX})) begin
                    nxt_op.duty_cycle = DUTY_MAX;
                    nxt_seg = SEG_HB_FREQ;
                end else if (aux_new <= $signed({17'h0000, DUTY_MIN})) begin
                    nxt_op.duty_cycle = DUTY_MIN;
                end else begin
                    nxt_op.duty_cycle = aux_new[14:0];
                end
            end
            SEG_HB_FREQ: begin
                nxt_op.duty_cycle = DUTY_MAX;
                if (f_new >= $signed({14'h0000, F_MAX_HZ})) begin
                    nxt_op.switching_frequency = F_MAX_HZ;
                    nxt_seg = SEG_HB_DUTY;
                end else if (extended_profile && f_new < $signed({14'h0000, F_HB_XO_HZ})) begin
                    nxt_op.full_bridge_mode = 1'b1;
                    nxt_op.switching_frequency = F_FB_XO_HZ;
                    nxt_op.phase_offset = PH_MAX;
                    nxt_seg = SEG_FB_PHASE;
                    xo = 1'b1;
                end else if (f_new < $signed({14'h0000, F_MIN_HZ})) begin
                    nxt_op.switching_frequency = F_MIN_HZ;
                end else begin
                    nxt_op.switching_frequency = f_new[17:0];
                end
            end
            SEG_FB_PHASE: begin
                aux_new = $signed({20'h00000, op_point_ff.phase_offset}) - d32;
                nxt_op.switching_frequency = F_FB_XO_HZ;
                if (aux_new <= 32'sh0000_0000) begin
                    nxt_op.phase_offset = 12'h000;
                    nxt_seg = SEG_FB_FREQ_LO;
                end else if (aux_new >= $signed({20'h00000, PH_MAX})) begin
                    nxt_op.phase_offset = PH_MAX;
                    nxt_seg = SEG_FB_FREQ_HI;
                end else begin
                    nxt_op.phase_offset = aux_new[11:0];
                end
            end
            SEG_FB_FREQ_LO: begin
                nxt_op.phase_offset = 12'h000;
                if (f_new >= $signed({14'h0000, F_FB_XO_HZ})) begin
                    nxt_op.switching_frequency = F_FB_XO_HZ;
                    nxt_seg = SEG_FB_PHASE;
                end else if (f_new < $signed({14'h0000, F_MIN_HZ})) begin
                    nxt_op.switching_frequency = F_MIN_HZ;
                end else begin
                    nxt_op.switching_frequency = f_new[17:0];
                end
            end
            SEG_FB_FREQ_HI: begin
                nxt_op.phase_offset = PH_MAX;
                if (f_new > $signed({14'h0000, F_MAX_HZ})) begin
                    nxt_op.full_bridge_mode = 1'b0;
                    nxt_op.switching_frequency = F_HB_XO_HZ;
                    nxt_op.duty_cycle = DUTY_MAX;
                    nxt_op.phase_offset = 12'h000;
                    nxt_seg = SEG_HB_FREQ;
                    xo = 1'b1;
                end else if (f_new <= $signed({14'h0000, F_FB_XO_HZ})) begin
                    nxt_op.switching_frequency = F_FB_XO_HZ;
                    nxt_seg = SEG_FB_PHASE;
                end else begin
                    nxt_op.switching_frequency = f_new[17:0];
                end
            end
            default: begin
                nxt_seg = SEG_HB_FREQ;
            end
        endcase
    end

    // ------------------------------------------------------------
    // operating point register
    // ------------------------------------------------------------
    // only a pid result, a ping or a profile drop out of full bridge moves the point; otherwise it is held
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            op_point_ff <= '{1'b0, F_PING_HZ, 12'h000, DUTY_MAX};
            seg_ff <= SEG_HB_FREQ;
            half_bridge_mode_ff <= 1'b1;
            crossover_ff <= 1'b0;
        end else begin
            crossover_ff <= 1'b0;
            if (ping_start) begin
                op_point_ff <= '{1'b0, F_PING_HZ, 12'h000, DUTY_MAX};
                seg_ff <= SEG_HB_FREQ;
                half_bridge_mode_ff <= 1'b1;
            end else if (!extended_profile && op_point_ff.full_bridge_mode) begin
                op_point_ff <= '{1'b0, F_HB_XO_HZ, 12'h000, DUTY_MAX};
                seg_ff <= SEG_HB_FREQ;
                half_bridge_mode_ff <= 1'b1;
            end else if (pid_valid && loop_active_ff) begin
                op_point_ff <= nxt_op;
                seg_ff <= nxt_seg;
                half_bridge_mode_ff <= !nxt_op.full_bridge_mode;
                crossover_ff <= xo;
            end
        end
    end

    // ------------------------------------------------------------
    // bridge pwm core
    // ------------------------------------------------------------
    // a phase accumulator dithers edges, so resolution holds on average
    // though each single edge still lands on the 50 ns grid
    logic [31:0] acc_ff;
    logic [31:0] inc_ff;
    logic [31:0] ph_word_ff;
    logic [15:0] duty_thr_ff;
    logic [41:0] inc_prod;
    logic [31:0] acc_b;
    logic [31:0] duty_prod;

    always_comb begin
        inc_prod = 42'(op_point_ff.switching_frequency) * 42'(F_INC_SCALE);
        duty_prod = 32'(op_point_ff.duty_cycle) * 32'(DUTY_THR_SCALE);
        acc_b = acc_ff - ph_word_ff;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            inc_ff <= 32'h0000_0000;
            ph_word_ff <= 32'h0000_0000;
            duty_thr_ff <= 16'h0000;
        end else begin
            inc_ff <= 32'(inc_prod[41:16]);
            ph_word_ff <= 32'(op_point_ff.phase_offset) * 32'(PH_WORD_SCALE);
            duty_thr_ff <= duty_prod[31:16];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            acc_ff <= 32'h0000_0000;
        end else if (!power_enable) begin
            acc_ff <= 32'h0000_0000;
        end else begin
            acc_ff <= acc_ff + inc_ff;
        end
    end

    // half bridge: leg b held off, leg a carries the duty
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            leg_a_drive_ff <= 1'b0;
            leg_b_drive_ff <= 1'b0;
        end else if (!power_enable) begin
            leg_a_drive_ff <= 1'b0;
            leg_b_drive_ff <= 1'b0;
        end else if (op_point_ff.full_bridge_mode) begin
            leg_a_drive_ff <= !acc_ff[31];
            leg_b_drive_ff <= !acc_b[31];
        end else begin
            leg_a_drive_ff <= acc_ff[31:16] < duty_thr_ff;
            leg_b_drive_ff <= 1'b0;
        end
    end
endmodule : idpc_ctrl
`default_nettype wire

//--- idpc_ctrl_sva.sv
// assertion checker for the inverter drive power controller
`default_nettype none
module idpc_ctrl_sva
    import idpc_pkg::*;
#(
    parameter int ITER_CYC = 50,
    parameter int LOOP_N = 2
)
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic power_enable,
    input wire logic ping_start,
    input wire logic extended_profile,
    input wire logic ctrl_err_valid,
    input wire logic [15:0] target_current_ma,
    input wire logic [15:0] coil_current_ma,
    input wire logic leg_a_drive_ff,
    input wire logic leg_b_drive_ff,
    input wire logic half_bridge_mode_ff,
    input wire idpc_op_t op_point_ff,
    input wire logic loop_active_ff,
    input wire logic crossover_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // ------------------------------------------------------------
    // operating point
    // ------------------------------------------------------------
    a_point_in_range: assert property (
        op_point_ff.switching_frequency inside {[F_MIN_HZ:F_MAX_HZ]} && op_point_ff.phase_offset <= PH_MAX
        && op_point_ff.duty_cycle inside {[DUTY_MIN:DUTY_MAX]}) else $error("operating point out of range");
    a_basic_half_only: assert property (!extended_profile && $past(!extended_profile) |->
        half_bridge_mode_ff && !op_point_ff.full_bridge_mode) else $error("full bridge in basic profile");
    a_hb_leg_b_idle: assert property (half_bridge_mode_ff [*4] |-> !leg_b_drive_ff)
        else $error("leg b driven in half bridge");
    a_hb_duty_full: assert property (
        half_bridge_mode_ff && op_point_ff.switching_frequency < F_MAX_HZ |-> op_point_ff.duty_cycle == DUTY_MAX)
        else $error("duty below half while frequency controls");
    a_fb_low_phase: assert property (
        !half_bridge_mode_ff && op_point_ff.switching_frequency < F_FB_XO_HZ |-> op_point_ff.phase_offset == 12'd0)
        else $error("phase nonzero below crossover frequency");
    a_ping_point: assert property (ping_start |=> half_bridge_mode_ff && !loop_active_ff
        && op_point_ff.duty_cycle == DUTY_MAX && op_point_ff.switching_frequency inside {[18'd170_000:18'd180_000]})
        else $error("ping point wrong");
    a_hold_idle: assert property (
        !loop_active_ff && !ping_start && (extended_profile || half_bridge_mode_ff)
        |=> $stable(op_point_ff) && $stable(half_bridge_mode_ff)) else $error("point moved while idle");
    a_xo_to_full: assert property (crossover_ff && !half_bridge_mode_ff |->
        op_point_ff.switching_frequency == F_FB_XO_HZ && op_point_ff.phase_offset == PH_MAX)
        else $error("wrong full bridge entry point");
    a_xo_to_half: assert property (crossover_ff && half_bridge_mode_ff |->
        op_point_ff.switching_frequency == F_HB_XO_HZ && op_point_ff.duty_cycle == DUTY_MAX)
        else $error("wrong half bridge entry point");
    a_xo_ends_loop: assert property (crossover_ff |-> !loop_active_ff && $changed(half_bridge_mode_ff))
        else $error("loop kept running after crossover");
    a_loop_starts: assert property (ctrl_err_valid && power_enable && !ping_start |=> loop_active_ff)
        else $error("message did not start loop");
    a_legs_off: assert property (!power_enable |=> !leg_a_drive_ff && !leg_b_drive_ff)
        else $error("legs driven while disabled");
    c_xo_full: cover property (crossover_ff && !half_bridge_mode_ff);
    c_xo_half: cover property (crossover_ff && half_bridge_mode_ff);
    c_ping: cover property (ping_start);
    c_loop: cover property ($fell(loop_active_ff));
endmodule : idpc_ctrl_sva

bind idpc_ctrl idpc_ctrl_sva #(.ITER_CYC(ITER_CYC), .LOOP_N(LOOP_N)) i_idpc_ctrl_sva (.clk_sys(clk_sys),
    .rst_b(rst_b), .power_enable(power_enable), .ping_start(ping_start), .extended_profile(extended_profile),
    .ctrl_err_valid(ctrl_err_valid), .target_current_ma(target_current_ma), .coil_current_ma(coil_current_ma),
    .leg_a_drive_ff(leg_a_drive_ff), .leg_b_drive_ff(leg_b_drive_ff), .half_bridge_mode_ff(half_bridge_mode_ff),
    .op_point_ff(op_point_ff), .loop_active_ff(loop_active_ff), .crossover_ff(crossover_ff));
`default_nettype wire

//--- idpc_coil_model.sv
// behavioural coil stage: coil current amplitude follows the delivered power
`default_nettype none
module idpc_coil_model
    import idpc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire idpc_op_t op_point,
    output logic [15:0] coil_current_ma
);
    timeunit 1ns;
    timeprecision 1ps;
    int amp;
    // ------------------------------------------------------------
    // current estimate
    // ------------------------------------------------------------
    // lower frequency, lower phase or higher duty give more current
    // floor near 2500 mA keeps every error large enough to saturate the frequency pid
    always_comb begin
        if (op_point.full_bridge_mode) begin
            amp = 6000 + (2500 - int'(op_point.phase_offset)) + (160000 - int'(op_point.switching_frequency)) / 40;
        end else begin
            amp = 2000 + int'(op_point.duty_cycle) / 10 + (205000 - int'(op_point.switching_frequency)) / 40;
        end
    end
    // 1 mA resolution on the measured amplitude
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            coil_current_ma <= 16'h07D0;
        end else begin
            coil_current_ma <= amp[15:0];
        end
    end
endmodule : idpc_coil_model
`default_nettype wire

//--- tb.sv
// self-checking testbench for the inverter drive power controller
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import idpc_pkg::*;
    logic clk_sys, rst_b, power_enable, ping_start, extended_profile, ctrl_err_valid;
    logic [15:0] target_current_ma, coil_current_ma;
    logic leg_a_drive_ff, leg_b_drive_ff, half_bridge_mode_ff, loop_active_ff, crossover_ff, xo_seen;
    idpc_op_t op_point_ff;
    logic [17:0] first_f;
    int n_fail = 0, samples_checked = 0, legb_high;

    idpc_ctrl #(.ITER_CYC(50), .LOOP_N(2)) i_idpc_ctrl (.clk_sys(clk_sys), .rst_b(rst_b),
        .power_enable(power_enable), .ping_start(ping_start), .extended_profile(extended_profile),
        .ctrl_err_valid(ctrl_err_valid), .target_current_ma(target_current_ma), .coil_current_ma(coil_current_ma),
        .leg_a_drive_ff(leg_a_drive_ff), .leg_b_drive_ff(leg_b_drive_ff), .half_bridge_mode_ff(half_bridge_mode_ff),
        .op_point_ff(op_point_ff), .loop_active_ff(loop_active_ff), .crossover_ff(crossover_ff));
    idpc_coil_model i_idpc_coil_model (.clk_sys(clk_sys), .rst_b(rst_b), .op_point(op_point_ff),
        .coil_current_ma(coil_current_ma));

    always #25 clk_sys = ~clk_sys;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
        end
    endtask : check

    // one message; notes the first new frequency and any crossover
    task automatic send_msg(input logic [15:0] tgt);
        int k;
        logic [17:0] f0;
        f0 = op_point_ff.switching_frequency;
        first_f = f0;
        xo_seen = 1'b0;
        k = 0;
        target_current_ma = tgt;
        ctrl_err_valid = 1'b1;
        tick(1);
        ctrl_err_valid = 1'b0;
        while (loop_active_ff !== 1'b0 && k < 200) begin
            tick(1);
            k++;
            if (crossover_ff === 1'b1) xo_seen = 1'b1;
            if (first_f === f0 && op_point_ff.switching_frequency !== f0) first_f = op_point_ff.switching_frequency;
        end
        check("loop finished", loop_active_ff, 1'b0);
    endtask : send_msg

    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        rst_b = 1'b0;
        power_enable = 1'b0;
        ping_start = 1'b0;
        extended_profile = 1'b0;
        ctrl_err_valid = 1'b0;
        target_current_ma = 16'h0000;
        tick(4);
        rst_b = 1'b1;
        tick(2);
        check("reset hb", half_bridge_mode_ff, 1'b1);
        check("reset freq", op_point_ff.switching_frequency, F_PING_HZ);
        check("reset duty", op_point_ff.duty_cycle, DUTY_MAX);
        $display("test reset done");
        power_enable = 1'b1;
        // basic profile: saturated pid, 3 Hz then 1 Hz band, clamp
        send_msg(16'hFDE8);
        check("basic first f", first_f, 18'd115_000);
        check("basic raise f", op_point_ff.switching_frequency, F_MIN_HZ);
        check("basic raise duty", op_point_ff.duty_cycle, DUTY_MAX);
        send_msg(16'h0000);
        check("basic first fall", first_f, 18'd130_000);
        check("basic fall f", op_point_ff.switching_frequency, F_FB_XO_HZ);
        send_msg(16'h0000);
        check("basic top f", op_point_ff.switching_frequency, F_MAX_HZ);
        check("basic duty cut", op_point_ff.duty_cycle < DUTY_MAX, 1'b1);
        check("basic hb", half_bridge_mode_ff, 1'b1);
        $display("test basic profile done");
        // extended profile: rising crossover from ping
        extended_profile = 1'b1;
        ping_start = 1'b1;
        tick(1);
        ping_start = 1'b0;
        check("ping f", op_point_ff.switching_frequency, F_PING_HZ);
        send_msg(16'hFDE8);
        check("rise xo", xo_seen, 1'b1);
        check("rise fb", half_bridge_mode_ff, 1'b0);
        tick(100);
        check("xo hold f", op_point_ff.switching_frequency, F_FB_XO_HZ);
        check("xo hold ph", op_point_ff.phase_offset, PH_MAX);
        send_msg(16'hFDE8);
        check("fb phase", op_point_ff.phase_offset, 12'd0);
        check("fb f", op_point_ff.switching_frequency, F_MIN_HZ);
        legb_high = 0;
        repeat (400) begin
            tick(1);
            if (leg_b_drive_ff === 1'b1) legb_high++;
        end
        check("fb leg b", legb_high > 0, 1'b1);
        // falling: f, phase, f, then crossover to half bridge
        repeat (5) begin
            if (half_bridge_mode_ff !== 1'b1) send_msg(16'h0000);
        end
        check("fall xo", xo_seen, 1'b1);
        check("fall f", op_point_ff.switching_frequency, F_HB_XO_HZ);
        check("fall duty", op_point_ff.duty_cycle, DUTY_MAX);
        $display("test extended profile done");
        // profile drop while in full bridge forces half bridge
        send_msg(16'hFDE8);
        check("again fb", half_bridge_mode_ff, 1'b0);
        extended_profile = 1'b0;
        tick(2);
        check("drop hb", half_bridge_mode_ff, 1'b1);
        power_enable = 1'b0;
        tick(3);
        check("legs off", {leg_a_drive_ff, leg_b_drive_ff}, 2'b00);
        $display("test profile drop done");
        results();
    end

    // bounded run: the tests need about 1250 cycles
    initial begin
        #1_000_000;
        n_fail++;
        results();
    end
endmodule : tb
`default_nettype wire
